/* File: torque_command_select_smooth.sv */
// torque command source selection, analog scaling and smoothing
// assumes select pins are asynchronous contacts and parameters are
// static or change from logic on the core clock
`timescale 1ns/1ps

// Operation
// - select pins 00 pick analog-or-zero, 01/10/11 pick presets 1/2/3.
// - code 00 in zero-torque mode gives exactly zero, analog ignored.
// - code 00 in analog mode takes the +/-10V reference, scaled.
// - any select pin high uses that preset, clamped to +/-300 percent.
// - a new preset applies three core clocks after either select pin changes.
// - open contact reads 0, closed contact reads 1.
// - source depends on both select pins and the control mode.
// - in position and speed modes the value is a torque limit.
// - analog command is smoothed with a 0..1000 ms time constant.
// - a zero time constant bypasses the smoothing stage.
// - analog full-scale parameter sets torque span of the reference.
module torque_command_select_smooth #(
  parameter int SAMPLE_CYCLES = torque_select_pkg::SAMPLE_CYCLES,
  parameter int SPM           = torque_select_pkg::SAMPLES_PER_MS
) (
  input  wire logic                                  CORE_CLK_I,
  input  wire logic                                  RSTN_I,
  input  wire logic                                  TORQUE_SELECT_BIT0_I,
  input  wire logic                                  TORQUE_SELECT_BIT1_I,
  input  wire torque_select_pkg::control_mode_t      CONTROL_MODE_SELECT_I,
  input  wire logic signed [15:0]                    ANALOG_REF_I,
  input  wire logic [15:0]                           ANALOG_TORQUE_FULL_SCALE_I,
  input  wire logic signed [15:0]                    INTERNAL_TORQUE_PRESET_1_I,
  input  wire logic signed [15:0]                    INTERNAL_TORQUE_PRESET_2_I,
  input  wire logic signed [15:0]                    INTERNAL_TORQUE_PRESET_3_I,
  input  wire logic [15:0]                           TORQUE_SMOOTHING_CONSTANT_I,
  output logic signed [15:0]                         TORQUE_COMMAND_O,
  output logic signed [15:0]                         TORQUE_LIMIT_O,
  output logic                                       TORQUE_LIMIT_ACTIVE_O,
  output logic [1:0]                                 TORQUE_SOURCE_O
);
  import torque_select_pkg::*;

  localparam int SCW = $clog2(SAMPLE_CYCLES + 1);

  initial begin
    if (SAMPLE_CYCLES < 64 || SPM < 1) begin
      $error("torque_command_select_smooth: unsupported parameters");
    end
  end

  // ****************************************************
  // select pin synchronisers
  // ****************************************************
  logic [1:0] sel_meta_reg;
  logic [1:0] sel_sync_reg;

  // contacts are asynchronous; meta stage feeds only the sync stage
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sel_meta_reg <= 2'h0;
      sel_sync_reg <= 2'h0;
    end else begin
      sel_meta_reg <= {TORQUE_SELECT_BIT1_I, TORQUE_SELECT_BIT0_I};
      sel_sync_reg <= sel_meta_reg;
    end
  end

  // ****************************************************
  // control sample tick
  // ****************************************************
  logic [SCW-1:0] tick_cnt_reg;
  logic           tick_reg;

  wire logic tick_wrap = tick_cnt_reg == SCW'(SAMPLE_CYCLES - 1);

  // free-running divider gives the filter its update rate
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + SCW'(1);
      tick_reg     <= tick_wrap;
    end
  end

  // ****************************************************
  // analog scaling and clamping
  // ****************************************************
  // signed code times full scale percent, full-scale code is 10 V
  wire logic signed [32:0] analog_prod =
    33'(ANALOG_REF_I) * $signed({17'h0, ANALOG_TORQUE_FULL_SCALE_I});
  wire logic signed [32:0] analog_shr  = analog_prod >>> ANALOG_SHIFT;
  wire logic               analog_hi   = analog_shr > 33'(TORQUE_MAX);
  wire logic               analog_lo   = analog_shr < 33'(TORQUE_MIN);
  wire logic signed [15:0] analog_trq  = analog_hi ? TORQUE_MAX :
                                         analog_lo ? TORQUE_MIN :
                                         analog_shr[15:0];

  // clamp the time constant so a bad setting cannot stretch the divider
  wire logic [15:0] tau_ms =
    (TORQUE_SMOOTHING_CONSTANT_I > SMOOTHING_MAX_MS) ?
    SMOOTHING_MAX_MS : TORQUE_SMOOTHING_CONSTANT_I;

  logic signed [15:0] analog_smooth;

  torque_lpf #(
    .W   (TORQUE_W),
    .FW  (FRAC_W),
    .SPM (SPM)
  ) u_lpf (
    .clk_i    (CORE_CLK_I),
    .rstn_i   (RSTN_I),
    .sample_i (tick_reg),
    .x_i      (analog_trq),
    .tau_i    (tau_ms),
    .y_o      (analog_smooth)
  );

  // bypass is immediate rather than waiting for the next sample
  wire logic signed [15:0] analog_path =
    (tau_ms == 16'h0000) ? analog_trq : analog_smooth;

  // ****************************************************
  // preset clamping
  // ****************************************************
  function automatic logic signed [15:0] clamp_pct(
    input logic signed [15:0] v
  );
    logic signed [15:0] r;
    r = v;
    if (v > TORQUE_MAX) begin
      r = TORQUE_MAX;
    end else if (v < TORQUE_MIN) begin
      r = TORQUE_MIN;
    end
    return r;
  endfunction : clamp_pct

  wire logic signed [15:0] preset_1 = clamp_pct(INTERNAL_TORQUE_PRESET_1_I);
  wire logic signed [15:0] preset_2 = clamp_pct(INTERNAL_TORQUE_PRESET_2_I);
  wire logic signed [15:0] preset_3 = clamp_pct(INTERNAL_TORQUE_PRESET_3_I);

  // ****************************************************
  // source selection
  // ****************************************************
  wire logic zero_mode  = CONTROL_MODE_SELECT_I == MODE_ZERO_TORQUE;
  wire logic torque_md  = (CONTROL_MODE_SELECT_I == MODE_TORQUE) ||
                          zero_mode;
  wire logic limit_md   = (CONTROL_MODE_SELECT_I == MODE_POSITION) ||
                          (CONTROL_MODE_SELECT_I == MODE_SPEED) ||
                          (CONTROL_MODE_SELECT_I == MODE_SPEED_ZERO);

  // zero-torque mode avoids analog zero drift entirely
  wire logic signed [15:0] base_path =
    zero_mode ? TORQUE_ZERO : analog_path;

  // pins and mode jointly pick the source, no sample wait for presets
  wire logic signed [15:0] selected =
    (sel_sync_reg == SEL_PRESET_1) ? preset_1 :
    (sel_sync_reg == SEL_PRESET_2) ? preset_2 :
    (sel_sync_reg == SEL_PRESET_3) ? preset_3 :
    base_path;

  // ****************************************************
  // output registers
  // ****************************************************
  logic signed [15:0] cmd_reg;
  logic signed [15:0] lim_reg;
  logic               lim_act_reg;
  logic [1:0]         src_reg;

  // command outside torque modes is steered onto the limit output
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cmd_reg     <= TORQUE_ZERO;
      lim_reg     <= TORQUE_ZERO;
      lim_act_reg <= 1'b0;
      src_reg     <= SEL_ANALOG;
    end else begin
      cmd_reg     <= torque_md ? selected : TORQUE_ZERO;
      lim_reg     <= limit_md ? selected : TORQUE_ZERO;
      lim_act_reg <= limit_md;
      src_reg     <= sel_sync_reg;
    end
  end

  assign TORQUE_COMMAND_O      = cmd_reg;
  assign TORQUE_LIMIT_O        = lim_reg;
  assign TORQUE_LIMIT_ACTIVE_O = lim_act_reg;
  assign TORQUE_SOURCE_O       = src_reg;

endmodule : torque_command_select_smooth

/* File: torque_select_pkg.sv */
// constants shared by the torque command selector and its smoothing stage
// assumes a 200 MHz core clock; all parameters arrive as plain inputs
package torque_select_pkg;

  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int SAMPLE_PERIOD_US = 100;  // control sample period
  localparam int SAMPLE_CYCLES   = SAMPLE_PERIOD_US * 1000000 / CLK_PERIOD_PS;
  localparam int SAMPLES_PER_MS  = 1000 / SAMPLE_PERIOD_US;

  // ****************************************************
  // parameter table
  // ****************************************************
  localparam logic [15:0] TORQUE_SMOOTHING_TIME_CONSTANT_ADDR = 16'h010e;
  localparam logic [15:0] TORQUE_SMOOTHING_TIME_CONSTANT_RST  = 16'h0000;
  localparam logic [15:0] SMOOTHING_MAX_MS                    = 16'h03e8;

  // ****************************************************
  // value ranges
  // ****************************************************
  localparam int TORQUE_W    = 16;
  localparam int FRAC_W      = 16;
  localparam int ANALOG_SHIFT = 15;  // analog code full scale is 2**15
  localparam logic signed [TORQUE_W-1:0] TORQUE_MAX = 16'sh012c;  // 300 %
  localparam logic signed [TORQUE_W-1:0] TORQUE_MIN = -16'sh012c;
  localparam logic signed [TORQUE_W-1:0] TORQUE_ZERO = 16'sh0000;

  // ****************************************************
  // select codes and control modes
  // ****************************************************
  localparam logic [1:0] SEL_ANALOG   = 2'h0;
  localparam logic [1:0] SEL_PRESET_1 = 2'h1;
  localparam logic [1:0] SEL_PRESET_2 = 2'h2;
  localparam logic [1:0] SEL_PRESET_3 = 2'h3;

  typedef enum logic [2:0] {
    MODE_TORQUE,
    MODE_ZERO_TORQUE,
    MODE_POSITION,
    MODE_SPEED,
    MODE_SPEED_ZERO
  } control_mode_t;

endpackage : torque_select_pkg

/* File: torque_lpf.sv */
// first-order recursive smoothing stage with serial divider
// assumes sample_i is a one-cycle pulse at least 40 cycles apart
`timescale 1ns/1ps
module torque_lpf #(
  parameter int W   = 16,
  parameter int FW  = 16,
  parameter int SPM = 10
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic                sample_i,
  input  wire logic signed [W-1:0] x_i,
  input  wire logic [15:0]         tau_i,
  output logic signed [W-1:0]      y_o
);
  import torque_select_pkg::*;

  localparam int AW = W + FW;
  localparam int DW = AW + 2;
  localparam int CW = $clog2(DW + 1);

  initial begin
    if (W < 2 || FW < 1 || SPM < 1) begin
      $error("torque_lpf: unsupported parameters");
    end
  end

  typedef enum logic {ST_IDLE, ST_DIV} lpf_state_t;

  lpf_state_t            state_reg;
  logic signed [AW-1:0]  acc_reg;
  logic [DW-1:0]         num_reg;
  logic [DW-1:0]         rem_reg;
  logic [DW-1:0]         den_reg;
  logic [CW-1:0]         cnt_reg;
  logic                  neg_reg;

  // ****************************************************
  // step size: distance to target divided by tau in samples plus one
  // ****************************************************
  // sign bit repeated so negative commands keep their sign once widened
  wire logic signed [AW:0]   x_wide   = {x_i[W-1], x_i, {FW{1'b0}}};
  wire logic signed [AW:0]   diff     = x_wide - {acc_reg[AW-1], acc_reg};
  wire logic                 diff_neg = diff[AW];
  wire logic [AW:0]          diff_mag = diff_neg ? 
                                         (AW + 1)'(-diff) : 
                                         (AW + 1)'(diff);
  wire logic [31:0]          den_full = 32'(tau_i) * 32'(SPM) + 32'h1;
  wire logic [DW-1:0]        rem_sh   = {rem_reg[DW-2:0], num_reg[DW-1]};
  wire logic                 rem_ge   = rem_sh >= den_reg;
  wire logic [DW-1:0]        rem_nx   = rem_ge ? rem_sh - den_reg : rem_sh;
  wire logic [DW-1:0]        quo_nx   = {num_reg[DW-2:0], rem_ge};
  wire logic signed [AW-1:0] step     = AW'(quo_nx);
  wire logic                 div_last = cnt_reg == CW'(DW - 1);

  // quotient shifts into num_reg as the dividend shifts out
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      acc_reg   <= '0;
      num_reg   <= '0;
      rem_reg   <= '0;
      den_reg   <= '0;
      cnt_reg   <= '0;
      neg_reg   <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (sample_i && tau_i == 16'h0000) begin
            acc_reg <= AW'(x_wide);
          end else if (sample_i) begin
            num_reg   <= DW'(diff_mag);
            rem_reg   <= '0;
            den_reg   <= DW'(den_full);
            neg_reg   <= diff_neg;
            cnt_reg   <= '0;
            state_reg <= ST_DIV;
          end
        end
        ST_DIV: begin
          num_reg <= quo_nx;
          rem_reg <= rem_nx;
          cnt_reg <= cnt_reg + CW'(1);
          if (div_last) begin
            acc_reg   <= neg_reg ? acc_reg - step : acc_reg + step;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign y_o = acc_reg[AW-1:FW];

endmodule : torque_lpf

/* File: torque_select_props.sv */
// assertions on the torque selector ports, bound to every instance
// assumes one clock domain, outputs registered on CORE_CLK_I
`timescale 1ns/1ps
module torque_select_props
  import torque_select_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 100,
  parameter int SPM           = 1
) (
  input wire logic                             CORE_CLK_I,
  input wire logic                             RSTN_I,
  input wire logic                             TORQUE_SELECT_BIT0_I,
  input wire logic                             TORQUE_SELECT_BIT1_I,
  input wire torque_select_pkg::control_mode_t CONTROL_MODE_SELECT_I,
  input wire logic signed [15:0]               ANALOG_REF_I,
  input wire logic [15:0]                      ANALOG_TORQUE_FULL_SCALE_I,
  input wire logic signed [15:0]               INTERNAL_TORQUE_PRESET_1_I,
  input wire logic signed [15:0]               INTERNAL_TORQUE_PRESET_2_I,
  input wire logic signed [15:0]               INTERNAL_TORQUE_PRESET_3_I,
  input wire logic [15:0]                      TORQUE_SMOOTHING_CONSTANT_I,
  input wire logic signed [15:0]               TORQUE_COMMAND_O,
  input wire logic signed [15:0]               TORQUE_LIMIT_O,
  input wire logic                             TORQUE_LIMIT_ACTIVE_O,
  input wire logic [1:0]                       TORQUE_SOURCE_O
);
  // ********
  // reference arithmetic, floor division keeps negative codes honest
  // ********
  function automatic logic signed [15:0] clip(input logic signed [33:0] v);
    return v > 300 ? 16'sh012c : (v < -300 ? 16'shfed4 : v[15:0]);
  endfunction : clip
  function automatic logic signed [15:0] scale(input logic signed [15:0] c,
                                               input logic [15:0] f);
    return clip((c * $signed({1'b0, f})) >>> 15);
  endfunction : scale
  default clocking dc @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // pins held for three cycles after reset is released, so the sync pipeline is full
  sequence pins_held;
    $stable(TORQUE_SELECT_BIT0_I) && $stable(TORQUE_SELECT_BIT1_I);
  endsequence
  chk_source_sync: assert property ($past(RSTN_I) ##0 pins_held[*3] |->
    TORQUE_SOURCE_O == {TORQUE_SELECT_BIT1_I, TORQUE_SELECT_BIT0_I})
    else $error("source code lags the select pins");
  chk_zero_torque: assert property ($past(CONTROL_MODE_SELECT_I) ==
    MODE_ZERO_TORQUE && TORQUE_SOURCE_O == SEL_ANALOG |-> TORQUE_COMMAND_O == 0)
    else $error("zero mode gave a nonzero command");
  chk_bypass_scale: assert property ($past(CONTROL_MODE_SELECT_I) ==
    MODE_TORQUE && TORQUE_SOURCE_O == SEL_ANALOG &&
    $past(TORQUE_SMOOTHING_CONSTANT_I) == 0 |-> TORQUE_COMMAND_O ==
    scale($past(ANALOG_REF_I), $past(ANALOG_TORQUE_FULL_SCALE_I)))
    else $error("bypassed analog command misscaled");
  chk_preset_one: assert property ($past(CONTROL_MODE_SELECT_I) ==
    MODE_TORQUE && TORQUE_SOURCE_O == SEL_PRESET_1 |->
    TORQUE_COMMAND_O == clip($past(INTERNAL_TORQUE_PRESET_1_I)))
    else $error("first preset not applied");
  chk_preset_three: assert property ($past(CONTROL_MODE_SELECT_I) ==
    MODE_TORQUE && TORQUE_SOURCE_O == SEL_PRESET_3 |->
    TORQUE_COMMAND_O == clip($past(INTERNAL_TORQUE_PRESET_3_I)))
    else $error("third preset not applied");
  chk_limit_preset: assert property ($past(CONTROL_MODE_SELECT_I) ==
    MODE_SPEED && TORQUE_SOURCE_O == SEL_PRESET_2 |->
    TORQUE_LIMIT_O == clip($past(INTERNAL_TORQUE_PRESET_2_I)))
    else $error("second preset not used as limit");
  chk_limit_flag: assert property (TORQUE_LIMIT_ACTIVE_O ==
    ($past(CONTROL_MODE_SELECT_I) inside {MODE_POSITION, MODE_SPEED,
    MODE_SPEED_ZERO})) else $error("limit flag disagrees with mode");
  chk_limit_no_cmd: assert property (TORQUE_LIMIT_ACTIVE_O |->
    TORQUE_COMMAND_O == 0) else $error("command driven in limit mode");
  chk_cmd_range: assert property (TORQUE_COMMAND_O <= 300 &&
    TORQUE_COMMAND_O >= -300) else $error("command beyond 300 percent");
  cover property (TORQUE_SOURCE_O == SEL_PRESET_3);
  cover property (TORQUE_LIMIT_ACTIVE_O);
  cover property ($past(TORQUE_SMOOTHING_CONSTANT_I) != 0 &&
                  $changed(TORQUE_COMMAND_O));
endmodule : torque_select_props

bind torque_command_select_smooth torque_select_props #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES), .SPM(SPM)) torque_select_props_i (
  .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
  .TORQUE_SELECT_BIT0_I(TORQUE_SELECT_BIT0_I),
  .TORQUE_SELECT_BIT1_I(TORQUE_SELECT_BIT1_I),
  .CONTROL_MODE_SELECT_I(CONTROL_MODE_SELECT_I),
  .ANALOG_REF_I(ANALOG_REF_I),
  .ANALOG_TORQUE_FULL_SCALE_I(ANALOG_TORQUE_FULL_SCALE_I),
  .INTERNAL_TORQUE_PRESET_1_I(INTERNAL_TORQUE_PRESET_1_I),
  .INTERNAL_TORQUE_PRESET_2_I(INTERNAL_TORQUE_PRESET_2_I),
  .INTERNAL_TORQUE_PRESET_3_I(INTERNAL_TORQUE_PRESET_3_I),
  .TORQUE_SMOOTHING_CONSTANT_I(TORQUE_SMOOTHING_CONSTANT_I),
  .TORQUE_COMMAND_O(TORQUE_COMMAND_O), .TORQUE_LIMIT_O(TORQUE_LIMIT_O),
  .TORQUE_LIMIT_ACTIVE_O(TORQUE_LIMIT_ACTIVE_O),
  .TORQUE_SOURCE_O(TORQUE_SOURCE_O));

/* File: torque_select_partner.sv */
// external controller closing and opening the two select contacts
// assumes the bench calls set_code; pins move just after a falling edge
`timescale 1ns/1ps
module torque_select_partner (
  input  wire logic clk_i,
  output logic      bit0_o,
  output logic      bit1_o
);
  // open contacts read as 0 until a code is commanded
  initial begin
    bit0_o = 1'b0;
    bit1_o = 1'b0;
  end
  // both contacts switch together, so the far side never sees an odd code
  task automatic set_code(input logic [1:0] c);
    @(negedge clk_i);
    bit1_o = c[1];
    bit0_o = c[0];
  endtask : set_code
endmodule : torque_select_partner

/* File: torque_command_select_smooth_test.sv */
// self-checking bench for the torque command selector
// assumes the bound checker and the contact partner model
`timescale 1ns/1ps
module torque_command_select_smooth_test;
  import torque_select_pkg::*;
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s expected %0d got %0d", nm, e, g); end end
  logic clk, rstn, b0, b1, act;
  control_mode_t mode;
  logic signed [15:0] aref, p1, p2, p3, cmd, lim;
  logic [15:0] fs, tau;
  logic [1:0] src;
  int mismatches = 0;
  int cmp_count = 0;
  // short sample period so the smoothing steps fit in the run
  torque_command_select_smooth #(.SAMPLE_CYCLES(100), .SPM(1))
    torque_command_select_smooth_i (.CORE_CLK_I(clk), .RSTN_I(rstn),
    .TORQUE_SELECT_BIT0_I(b0), .TORQUE_SELECT_BIT1_I(b1),
    .CONTROL_MODE_SELECT_I(mode), .ANALOG_REF_I(aref),
    .ANALOG_TORQUE_FULL_SCALE_I(fs), .INTERNAL_TORQUE_PRESET_1_I(p1),
    .INTERNAL_TORQUE_PRESET_2_I(p2), .INTERNAL_TORQUE_PRESET_3_I(p3),
    .TORQUE_SMOOTHING_CONSTANT_I(tau), .TORQUE_COMMAND_O(cmd),
    .TORQUE_LIMIT_O(lim), .TORQUE_LIMIT_ACTIVE_O(act),
    .TORQUE_SOURCE_O(src));
  torque_select_partner torque_select_partner_i (.clk_i(clk), .bit0_o(b0),
    .bit1_o(b1));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic give_verdict;
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // presets back to back; the third one is above range and must clip
  task automatic t_presets;
    logic signed [15:0] e [4] = '{16'sh0, 16'sh0064, 16'shfed4, 16'sh012c};
    mode = MODE_TORQUE;
    for (int c = 1; c <= 3; c++) begin
      torque_select_partner_i.set_code(2'(c));
      settle(4);
      `CHK("source", 2'(c), src)
      `CHK("preset", e[c], cmd)
    end
  endtask : t_presets
  // code 00 in zero mode ignores a live analog input
  task automatic t_zero;
    mode = MODE_ZERO_TORQUE;
    aref = 16'sh4000;
    torque_select_partner_i.set_code(2'h0);
    settle(4);
    `CHK("zero cmd", 16'sh0, cmd)
    mode = MODE_TORQUE;
    settle(2);
    `CHK("analog cmd", 16'sh0032, cmd)
  endtask : t_zero
  // bypass scaling, including the clip and floor of negative codes
  task automatic t_analog;
    logic signed [15:0] a [4] = '{16'sh4000, 16'sh8000, 16'sh7fff, 16'shffff};
    logic [15:0] f [4] = '{16'h0064, 16'h012c, 16'h0190, 16'h0064};
    logic signed [15:0] e [4] = '{16'sh0032, 16'shfed4, 16'sh012c, -16'sh1};
    for (int i = 0; i < 4; i++) begin
      aref = a[i];
      fs = f[i];
      settle(2);
      `CHK("scaled", e[i], cmd)
    end
  endtask : t_analog
  // preset two as a limit in each limiting mode, then back to torque
  task automatic t_limit;
    control_mode_t m [3] = '{MODE_POSITION, MODE_SPEED, MODE_SPEED_ZERO};
    torque_select_partner_i.set_code(2'h2);
    settle(4);
    for (int i = 0; i < 3; i++) begin
      mode = m[i];
      settle(2);
      `CHK("limit", 16'shfed4, lim)
      `CHK("limit on", 1'b1, act)
      `CHK("no cmd", 16'sh0, cmd)
    end
    mode = MODE_TORQUE;
    settle(2);
    `CHK("limit off", 1'b0, act)
  endtask : t_limit
  task automatic next_val(input logic signed [15:0] e);
    logic signed [15:0] old;
    old = cmd;
    for (int i = 0; i < 300 && cmd === old; i++) @(negedge clk);
    `CHK("smoothed", e, cmd)
  endtask : next_val
  // a step into a one-sample lag halves the gap at every sample
  task automatic t_filter;
    torque_select_partner_i.set_code(2'h0);
    tau = 16'h0;
    aref = 16'sh0;
    fs = 16'h00c8;
    settle(300);
    aref = 16'sh4000;
    tau = 16'h0001;
    next_val(16'sh0032);
    next_val(16'sh004b);
    next_val(16'sh0057);
  endtask : t_filter
  initial begin
    rstn = 1'b0;
    mode = MODE_TORQUE;
    aref = 16'sh0;
    fs = 16'h0064;
    p1 = 16'sh0064;
    p2 = 16'shfed4;
    p3 = 16'sh0190;
    tau = 16'h0;
    settle(3);
    rstn = 1'b1;
    t_presets();
    t_zero();
    t_analog();
    t_limit();
    t_filter();
    give_verdict();
  end
  // the whole sequence needs well under 3000 cycles
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule : torque_command_select_smooth_test
